// File: hdl/tcc_pkg.sv
// Purpose: Shared constants for the timer capture/compare control block
// Assumes: Registers are 8 or 16 bits wide, one per aligned 32-bit word
// Notes: Printed offsets are register indices; byte address is 4x (index - base)
package tcc_pkg;
    // Printed register offsets (indices)
    localparam logic [31:0] TCC_IDX_BASE = 32'h40042a70;
    localparam logic [31:0] TCC_IDX_CTL0 = 32'h40042a70;
    localparam logic [31:0] TCC_IDX_AB0 = 32'h40042a71;
    localparam logic [31:0] TCC_IDX_CD0 = 32'h40042a72;
    localparam logic [31:0] TCC_IDX_CTL1 = 32'h40042a80;
    localparam logic [31:0] TCC_IDX_AB1 = 32'h40042a81;
    localparam logic [31:0] TCC_IDX_CD1 = 32'h40042a82;
    // Additional registers, byte addresses
    localparam logic [11:0] TCC_ADR_FCR = 12'h050;
    localparam logic [11:0] TCC_ADR_CNT0 = 12'h058;
    localparam logic [11:0] TCC_ADR_CNT1 = 12'h05c;
    localparam logic [11:0] TCC_ADR_GR = 12'h060;
    // Reset values and masks
    localparam logic [7:0] TCC_RST_CTL = 8'h00;
    localparam logic [7:0] TCC_RST_AB = 8'h00;
    localparam logic [7:0] TCC_RST_CD = 8'h88;
    localparam logic [7:0] TCC_RST_FCR = 8'h00;
    localparam logic [7:0] TCC_AB_MASK = 8'h77;
    localparam logic [7:0] TCC_FCR_MASK = 8'h0f;
    // Field positions
    localparam int TCC_CTL_SRC = 0;
    localparam int TCC_CTL_EDGE = 3;
    localparam int TCC_CTL_CLR = 5;
    localparam int TCC_FCR_EXTEN = 0;
    localparam int TCC_FCR_MODE = 1;
    localparam int TCC_FCR_RUN = 3;
    // Count source codes
    localparam logic [2:0] TCC_SRC_DIV1 = 3'h0;
    localparam logic [2:0] TCC_SRC_DIV2 = 3'h1;
    localparam logic [2:0] TCC_SRC_DIV4 = 3'h2;
    localparam logic [2:0] TCC_SRC_DIV8 = 3'h3;
    localparam logic [2:0] TCC_SRC_DIV32 = 3'h4;
    localparam logic [2:0] TCC_SRC_EXT = 3'h5;
    // Edge codes, shared by external clock and capture
    localparam logic [1:0] TCC_EDGE_RISE = 2'h0;
    localparam logic [1:0] TCC_EDGE_FALL = 2'h1;
    localparam logic [1:0] TCC_EDGE_BOTH = 2'h2;
    // Compare output actions
    localparam logic [1:0] TCC_OUT_OFF = 2'h0;
    localparam logic [1:0] TCC_OUT_LOW = 2'h1;
    localparam logic [1:0] TCC_OUT_HIGH = 2'h2;
    localparam logic [1:0] TCC_OUT_TOG = 2'h3;
    // Counter clear codes
    localparam logic [2:0] TCC_CLR_FREE = 3'h0;
    localparam logic [2:0] TCC_CLR_A = 3'h1;
    localparam logic [2:0] TCC_CLR_B = 3'h2;
    localparam logic [2:0] TCC_CLR_SYNC = 3'h3;
    localparam logic [2:0] TCC_CLR_C = 3'h5;
    localparam logic [2:0] TCC_CLR_D = 3'h6;
    // Bus responses
    localparam logic [1:0] TCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] TCC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {TCC_MODE_NORMAL, TCC_MODE_COMPL, TCC_MODE_3PH, TCC_MODE_RSVD} tcc_mode_t;

    // Byte address of a printed register index
    function automatic logic [11:0] tcc_adr(input logic [31:0] idx);
        logic [31:0] d;
        d = (idx - TCC_IDX_BASE) << 2;
        return d[11:0];
    endfunction

    // Edge hit for a field coded rise, fall or both
    function automatic logic tcc_edge(input logic [1:0] sel, input logic cur, input logic prv);
        return (sel == TCC_EDGE_RISE) ? (cur & ~prv) :
               (sel == TCC_EDGE_FALL) ? (~cur & prv) :
               (sel == TCC_EDGE_BOTH) ? (cur ^ prv) : 1'b0;
    endfunction
endpackage

// File: hdl/tcc_chan_if.sv
// Purpose: Carries configuration and status between control and one channel
// Assumes: Both ends on CORE_CLK
// Notes: Pin inputs arrive already synchronised
`timescale 1ns/10ps
interface tcc_chan_if;
    logic [7:0] ctl;
    logic [7:0] ab;
    logic [7:0] cd;
    logic tick;
    logic sync_clr;
    logic [3:0] pin_in;
    logic [3:0] gr_we;
    logic [15:0] gr_wdata;
    logic [15:0] cnt;
    logic [63:0] gr;
    logic [3:0] pin_out;
    logic [3:0] pin_oe_n;
    logic clr_evt;

    modport ctrl (output ctl, ab, cd, tick, sync_clr, pin_in, gr_we, gr_wdata,
                  input cnt, gr, pin_out, pin_oe_n, clr_evt);
    modport chan (input ctl, ab, cd, tick, sync_clr, pin_in, gr_we, gr_wdata,
                  output cnt, gr, pin_out, pin_oe_n, clr_evt);
endinterface

// File: hdl/tcc_chan.sv
// Purpose: One timer channel: counter, four general registers, capture and compare
// Assumes: Tick is a one-cycle enable; pin inputs are synchronised
// Notes: Index 0..3 stands for registers and pins A, B, C, D
`timescale 1ns/10ps
module tcc_chan
    import tcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control side
    tcc_chan_if.chan ch
);
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] gr_r [4], gr_nxt [4];
    logic [3:0] prev_r, prev_nxt;
    logic [3:0] pout_r, pout_nxt;
    logic [3:0] oen_r, oen_nxt;
    logic [3:0] mode, fsel, match, cap;
    logic [1:0] fld [4];
    logic clr_own, clr_all;

    // Field split of the two I/O control registers
    always_comb
    begin
        mode = {ch.cd[6], ch.cd[2], ch.ab[6], ch.ab[2]};
        fsel = {ch.cd[7], ch.cd[3], 2'b11};
        fld[0] = ch.ab[1:0];
        fld[1] = ch.ab[5:4];
        fld[2] = ch.cd[1:0];
        fld[3] = ch.cd[5:4];
    end

    // Capture, compare, counter and pin next values
    always_comb
    begin
        cnt_nxt = cnt_r;
        pout_nxt = pout_r;
        oen_nxt = 4'hf;
        prev_nxt = ch.pin_in;
        for (int k = 0; k < 4; k++)
        begin
            gr_nxt[k] = gr_r[k];
            match[k] = ch.tick & ~mode[k] & (cnt_r == gr_r[k]);
            cap[k] = mode[k] & tcc_edge(fld[k], ch.pin_in[k], prev_r[k]);
            if (ch.gr_we[k])
                gr_nxt[k] = ch.gr_wdata;
            if (cap[k])
                gr_nxt[k] = cnt_r;
        end
        // C and D act on pins A and B when function select is 0
        for (int k = 0; k < 4; k++)
        begin
            if (!mode[k] && fld[k] != TCC_OUT_OFF)
            begin
                oen_nxt[fsel[k] ? k : k - 2] = 1'b0;
                if (match[k])
                begin
                    case (fld[k])
                        TCC_OUT_LOW: pout_nxt[fsel[k] ? k : k - 2] = 1'b0;
                        TCC_OUT_HIGH: pout_nxt[fsel[k] ? k : k - 2] = 1'b1;
                        default: pout_nxt[fsel[k] ? k : k - 2] = ~pout_r[fsel[k] ? k : k - 2];
                    endcase
                end
            end
        end
        // Counter clear by own event or by the partner channel
        case (ch.ctl[TCC_CTL_CLR +: 3])
            TCC_CLR_A: clr_own = match[0] | cap[0];
            TCC_CLR_B: clr_own = match[1] | cap[1];
            TCC_CLR_C: clr_own = match[2] | cap[2];
            TCC_CLR_D: clr_own = match[3] | cap[3];
            default: clr_own = 1'b0;
        endcase
        clr_all = clr_own | (ch.ctl[TCC_CTL_CLR +: 3] == TCC_CLR_SYNC && ch.sync_clr);
        if (clr_all)
            cnt_nxt = '0;
        else if (ch.tick)
            cnt_nxt = cnt_r + 16'h0001;
    end

    // Channel state registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 16'h0000;
            prev_r <= 4'h0;
            pout_r <= 4'h0;
            oen_r <= 4'hf;
            for (int k = 0; k < 4; k++)
                gr_r[k] <= 16'hffff;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            prev_r <= prev_nxt;
            pout_r <= pout_nxt;
            oen_r <= oen_nxt;
            for (int k = 0; k < 4; k++)
                gr_r[k] <= gr_nxt[k];
        end
    end

    assign ch.cnt = cnt_r;
    assign ch.gr = {gr_r[3], gr_r[2], gr_r[1], gr_r[0]};
    assign ch.pin_out = pout_r;
    assign ch.pin_oe_n = oen_r;
    assign ch.clr_evt = clr_own;

    a_cap_rise_value: assert property (@(posedge clk) disable iff (!rst_n)
        (mode[0] && fld[0] == TCC_EDGE_RISE && ch.pin_in[0] && !prev_r[0])
        |=> gr_r[0] == $past(cnt_r))
        else $error("rising capture did not load counter into A");
    a_cmp_drive_low: assert property (@(posedge clk) disable iff (!rst_n)
        (match[0] && fld[0] == TCC_OUT_LOW && !(match[2] && !fsel[2]))
        |=> !pout_r[0] && !oen_r[0])
        else $error("low-on-match did not drive pin A low");
    a_cmp_toggle_pin: assert property (@(posedge clk) disable iff (!rst_n)
        (match[1] && fld[1] == TCC_OUT_TOG && !(match[3] && !fsel[3]))
        |=> pout_r[1] != $past(pout_r[1]))
        else $error("toggle-on-match did not invert pin B");
    a_c_drives_a: assert property (@(posedge clk) disable iff (!rst_n)
        (match[2] && !fsel[2] && fld[2] == TCC_OUT_HIGH)
        |=> pout_r[0] && !oen_r[0])
        else $error("C compare did not drive pin A high");
    c_capture_a: cover property (@(posedge clk) disable iff (!rst_n) cap[0]);
    c_toggle_b: cover property (@(posedge clk) disable iff (!rst_n)
        match[1] && fld[1] == TCC_OUT_TOG);
endmodule

// File: hdl/tcc_top.sv
// Purpose: Timer capture/compare control with AXI4-Lite registers
// Assumes: Single clock CORE_CLK at 40 MHz; pins are asynchronous to it
// Notes: Two channels; channel logic lives in tcc_chan
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module tcc_top
    import tcc_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    // AXI4-Lite write
    input wire logic [11:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // AXI4-Lite read
    input wire logic [11:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // External count clock pin
    input wire logic EXT_COUNT_CLOCK_PIN,
    // Channel 0 pins A..D
    input wire logic [3:0] PIN_IO_IN0,
    output logic [3:0] PIN_IO_OUT0,
    output logic [3:0] PIN_IO_OE_N0,
    // Channel 1 pins A..D
    input wire logic [3:0] PIN_IO_IN1,
    output logic [3:0] PIN_IO_OUT1,
    output logic [3:0] PIN_IO_OE_N1
);
    tcc_chan_if c0 ();
    tcc_chan_if c1 ();

    logic [7:0] ctl0_r, ctl0_nxt, ctl1_r, ctl1_nxt;
    logic [7:0] ab0_r, ab0_nxt, ab1_r, ab1_nxt;
    logic [7:0] cd0_r, cd0_nxt, cd1_r, cd1_nxt;
    logic [7:0] fcr_r, fcr_nxt;
    logic [11:0] awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic [3:0] ws_r, ws_nxt;
    logic awh_r, awh_nxt, wh_r, wh_nxt;
    logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
    logic bv_r, bv_nxt, rv_r, rv_nxt, arrdy_r, arrdy_nxt;
    logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [4:0] pre_r, pre_nxt;
    logic [2:0] ext_r;
    logic [3:0] p0s1_r, p0s2_r, p1s1_r, p1s2_r;
    logic tick0_r, tick0_nxt, tick1_r, tick1_nxt;
    logic do_wr, ext_en, run;
    tcc_mode_t mode;
    logic [3:0] gwe0, gwe1;

    // Channel instances
    tcc_chan u_ch0 (.clk(CORE_CLK), .rst_n(ARST_N), .ch(c0.chan));
    tcc_chan u_ch1 (.clk(CORE_CLK), .rst_n(ARST_N), .ch(c1.chan));

    assign ext_en = fcr_r[TCC_FCR_EXTEN];
    assign run = fcr_r[TCC_FCR_RUN];
    assign mode = tcc_mode_t'(fcr_r[TCC_FCR_MODE +: 2]);

    // Count tick for one channel from its source and edge fields
    function automatic logic tick_f(input logic [7:0] ctl);
        logic hit;
        hit = tcc_edge(ctl[TCC_CTL_EDGE +: 2], ext_r[1], ext_r[2]);
        case (ctl[TCC_CTL_SRC +: 3])
            TCC_SRC_DIV1: tick_f = 1'b1;
            TCC_SRC_DIV2: tick_f = pre_r[0];
            TCC_SRC_DIV4: tick_f = &pre_r[1:0];
            TCC_SRC_DIV8: tick_f = &pre_r[2:0];
            TCC_SRC_DIV32: tick_f = &pre_r[4:0];
            // external source gated by enable and mode
            TCC_SRC_EXT: tick_f = ext_en && mode != TCC_MODE_3PH && hit;
            default: tick_f = 1'b0;
        endcase
    endfunction

    // Byte address decode for 16-bit general registers: returns one-hot of 8
    function automatic logic [7:0] gr_sel(input logic [11:0] a);
        gr_sel = 8'h00;
        if (a >= TCC_ADR_GR && a < TCC_ADR_GR + 12'h020 && a[1:0] == 2'b00)
            gr_sel[3'(a[4:2])] = 1'b1;
    endfunction

    // Read mux with decode error flag in bit 32
    function automatic logic [32:0] rd_f(input logic [11:0] a);
        logic [7:0] g;
        g = gr_sel(a);
        if (a == tcc_adr(TCC_IDX_CTL0))
            rd_f = {25'h0, ctl0_r};
        else if (a == tcc_adr(TCC_IDX_AB0))
            rd_f = {25'h0, ab0_r};
        else if (a == tcc_adr(TCC_IDX_CD0))
            rd_f = {25'h0, cd0_r};
        else if (a == tcc_adr(TCC_IDX_CTL1))
            rd_f = {25'h0, ctl1_r};
        else if (a == tcc_adr(TCC_IDX_AB1))
            rd_f = {25'h0, ab1_r};
        else if (a == tcc_adr(TCC_IDX_CD1))
            rd_f = {25'h0, cd1_r};
        else if (a == TCC_ADR_FCR)
            rd_f = {25'h0, fcr_r};
        else if (a == TCC_ADR_CNT0)
            rd_f = {17'h0, c0.cnt};
        else if (a == TCC_ADR_CNT1)
            rd_f = {17'h0, c1.cnt};
        else if (|g[3:0])
            rd_f = {17'h0, c0.gr[16 * a[3:2] +: 16]};
        else if (|g[7:4])
            rd_f = {17'h0, c1.gr[16 * a[3:2] +: 16]};
        else
            rd_f = {1'b1, 32'h0};
    endfunction

    // Bus handshakes and register writes
    always_comb
    begin
        logic [32:0] rv;
        logic [7:0] b0;
        logic [32:0] wrv;
        rv = rd_f(ARADDR);
        b0 = wd_r[7:0];
        // Decode of the held write address, error flag in bit 32
        wrv = rd_f(awa_r);
        {ctl0_nxt, ab0_nxt, cd0_nxt} = {ctl0_r, ab0_r, cd0_r};
        {ctl1_nxt, ab1_nxt, cd1_nxt, fcr_nxt} = {ctl1_r, ab1_r, cd1_r, fcr_r};
        awa_nxt = awa_r;
        wd_nxt = wd_r;
        ws_nxt = ws_r;
        awh_nxt = awh_r | (AWVALID & awrdy_r);
        wh_nxt = wh_r | (WVALID & wrdy_r);
        if (AWVALID && awrdy_r)
            awa_nxt = AWADDR;
        if (WVALID && wrdy_r)
        begin
            wd_nxt = WDATA;
            ws_nxt = WSTRB;
        end
        bv_nxt = bv_r & ~BREADY;
        br_nxt = br_r;
        do_wr = awh_r & wh_r & ~bv_r;
        gwe0 = 4'h0;
        gwe1 = 4'h0;
        if (do_wr)
        begin
            awh_nxt = 1'b0;
            wh_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = TCC_RESP_OKAY;
            if (ws_r[0])
            begin
                if (awa_r == tcc_adr(TCC_IDX_CTL0))
                    ctl0_nxt = b0;
                else if (awa_r == tcc_adr(TCC_IDX_AB0))
                    ab0_nxt = b0 & TCC_AB_MASK;
                else if (awa_r == tcc_adr(TCC_IDX_CD0))
                    cd0_nxt = b0;
                else if (awa_r == tcc_adr(TCC_IDX_CTL1))
                    ctl1_nxt = b0;
                else if (awa_r == tcc_adr(TCC_IDX_AB1))
                    ab1_nxt = b0 & TCC_AB_MASK;
                else if (awa_r == tcc_adr(TCC_IDX_CD1))
                    cd1_nxt = b0;
                else if (awa_r == TCC_ADR_FCR)
                    fcr_nxt = b0 & TCC_FCR_MASK;
            end
            if (&ws_r[1:0])
                {gwe1, gwe0} = gr_sel(awa_r);
            if (wrv[32] || awa_r == TCC_ADR_CNT0 || awa_r == TCC_ADR_CNT1)
                br_nxt = TCC_RESP_SLVERR;
        end
        awrdy_nxt = ~awh_nxt;
        wrdy_nxt = ~wh_nxt;
        rv_nxt = rv_r & ~RREADY;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        arrdy_nxt = arrdy_r;
        if (ARVALID && arrdy_r)
        begin
            rv_nxt = 1'b1;
            arrdy_nxt = 1'b0;
            rd_nxt = rv[31:0];
            rr_nxt = rv[32] ? TCC_RESP_SLVERR : TCC_RESP_OKAY;
        end
        else if (rv_r && RREADY)
            arrdy_nxt = 1'b1;
    end

    // Prescaler and tick next values
    always_comb
    begin
        pre_nxt = pre_r + 5'h01;
        tick0_nxt = run & tick_f(ctl0_r);
        tick1_nxt = run & tick_f(ctl1_r);
    end

    // Register and synchroniser state
    always_ff @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            {ctl0_r, ctl1_r, fcr_r} <= {TCC_RST_CTL, TCC_RST_CTL, TCC_RST_FCR};
            {ab0_r, ab1_r, cd0_r, cd1_r} <= {TCC_RST_AB, TCC_RST_AB, TCC_RST_CD, TCC_RST_CD};
            {awa_r, wd_r, ws_r, awh_r, wh_r} <= '0;
            {awrdy_r, wrdy_r, arrdy_r} <= 3'b111;
            {bv_r, br_r, rv_r, rr_r, rd_r} <= '0;
            {pre_r, ext_r, tick0_r, tick1_r} <= '0;
            {p0s1_r, p0s2_r, p1s1_r, p1s2_r} <= '0;
        end
        else
        begin
            {ctl0_r, ctl1_r, fcr_r} <= {ctl0_nxt, ctl1_nxt, fcr_nxt};
            {ab0_r, ab1_r, cd0_r, cd1_r} <= {ab0_nxt, ab1_nxt, cd0_nxt, cd1_nxt};
            {awa_r, wd_r, ws_r, awh_r, wh_r} <= {awa_nxt, wd_nxt, ws_nxt, awh_nxt, wh_nxt};
            {awrdy_r, wrdy_r, arrdy_r} <= {awrdy_nxt, wrdy_nxt, arrdy_nxt};
            {bv_r, br_r, rv_r, rr_r, rd_r} <= {bv_nxt, br_nxt, rv_nxt, rr_nxt, rd_nxt};
            {pre_r, tick0_r, tick1_r} <= {pre_nxt, tick0_nxt, tick1_nxt};
            ext_r <= {ext_r[1:0], EXT_COUNT_CLOCK_PIN};
            {p0s1_r, p0s2_r} <= {PIN_IO_IN0, p0s1_r};
            {p1s1_r, p1s2_r} <= {PIN_IO_IN1, p1s1_r};
        end
    end

    // Channel hookup
    assign c0.ctl = ctl0_r;
    assign c0.ab = ab0_r;
    assign c0.cd = cd0_r;
    assign c0.tick = tick0_r;
    assign c0.sync_clr = c1.clr_evt;
    assign c0.pin_in = p0s2_r;
    assign c0.gr_we = gwe0;
    assign c0.gr_wdata = wd_r[15:0];
    assign c1.ctl = ctl1_r;
    assign c1.ab = ab1_r;
    assign c1.cd = cd1_r;
    assign c1.tick = tick1_r;
    assign c1.sync_clr = c0.clr_evt;
    assign c1.pin_in = p1s2_r;
    assign c1.gr_we = gwe1;
    assign c1.gr_wdata = wd_r[15:0];

    // Outputs
    assign {AWREADY, WREADY, BVALID, BRESP} = {awrdy_r, wrdy_r, bv_r, br_r};
    assign {ARREADY, RVALID, RRESP, RDATA} = {arrdy_r, rv_r, rr_r, rd_r};
    assign {PIN_IO_OUT0, PIN_IO_OE_N0} = {c0.pin_out, c0.pin_oe_n};
    assign {PIN_IO_OUT1, PIN_IO_OE_N1} = {c1.pin_out, c1.pin_oe_n};

    a_ab_fixed_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        ((ab0_r | ab1_r) & ~TCC_AB_MASK) == 8'h00)
        else $error("fixed-zero bit set in A/B I/O control");
    a_div2_tick: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (run && ctl0_r[2:0] == TCC_SRC_DIV2 && pre_r[0]) |=> tick0_r)
        else $error("divide-by-2 tick missing");
    a_div32_gap: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (ctl0_r[2:0] == TCC_SRC_DIV32 && pre_r != 5'h1f) |=> !tick0_r)
        else $error("divide-by-32 ticked off phase");
    a_ext_enable_off: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (ctl0_r[2:0] == TCC_SRC_EXT && !ext_en) |=> !tick0_r)
        else $error("external tick while enable is 0");
    a_ext_rise_count: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (run && ext_en && mode != TCC_MODE_3PH && ctl0_r[7:3] ==? 5'b???00
         && ctl0_r[2:0] == TCC_SRC_EXT && ext_r[1] && !ext_r[2]) |=> tick0_r)
        else $error("rising external edge not counted");
    a_ext_fall_only: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (ctl0_r[4:0] == {TCC_EDGE_FALL, TCC_SRC_EXT} && !(!ext_r[1] && ext_r[2]))
        |=> !tick0_r)
        else $error("falling-edge select counted another edge");
    a_3ph_ignore_ext: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (mode == TCC_MODE_3PH && ctl1_r[2:0] == TCC_SRC_EXT) |=> !tick1_r)
        else $error("external edge counted in three-phase mode");
    c_slverr_read: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
        rv_r && rr_r == TCC_RESP_SLVERR);
    // Main scenarios reached by the bench
    c_ext_tick: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
        run && ext_en && tick1_r);
    c_three_phase_ext: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
        mode == TCC_MODE_3PH && ctl1_r[2:0] == TCC_SRC_EXT);
endmodule

// File: dv/tcc_pin_model.sv
// Purpose: Far-side model of one channel's four timer pins
// Assumes: A pin left undriven by the block follows the level the bench asks for
// Notes: A pin driven by the block reads back the block's own level
`timescale 1ns/10ps
module tcc_pin_model
(
    // Block side
    input wire logic [3:0] out,
    input wire logic [3:0] oe_n,
    // Bench side
    input wire logic [3:0] drv,
    output logic [3:0] pin
);
    assign pin = (oe_n & drv) | (~oe_n & out);
endmodule

// File: dv/testbench.sv
// Purpose: Self-checking bench for the timer capture/compare control block
// Assumes: Registers reached over AXI4-Lite, one aligned word each
// Notes: Covers reset values, masked bits, compare, capture and external count
`timescale 1ns/10ps
`define CHK(n, e, g) \
    begin tests_run++; if ((g) !== (e)) \
    begin errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
    import tcc_pkg::*;
    logic clk, arst_n, awv, wv, bready, arv, rready, ext, awr, wrdy, bv, arr, rv;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [3:0] drv0, drv1, in0, in1, out0, out1, oe0, oe1;
    int errors, tests_run, cyc;
    // Block under test
    tcc_top u_tcc_top (.CORE_CLK(clk), .ARST_N(arst_n), .AWADDR(awaddr), .AWVALID(awv),
        .AWREADY(awr), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wv), .WREADY(wrdy),
        .BRESP(bresp), .BVALID(bv), .BREADY(bready), .ARADDR(araddr), .ARVALID(arv),
        .ARREADY(arr), .RDATA(rdata), .RRESP(rresp), .RVALID(rv), .RREADY(rready),
        .EXT_COUNT_CLOCK_PIN(ext), .PIN_IO_IN0(in0), .PIN_IO_OUT0(out0),
        .PIN_IO_OE_N0(oe0), .PIN_IO_IN1(in1), .PIN_IO_OUT1(out1), .PIN_IO_OE_N1(oe1));
    // Far-side pins
    tcc_pin_model u_pm0 (.out(out0), .oe_n(oe0), .drv(drv0), .pin(in0));
    tcc_pin_model u_pm1 (.out(out1), .oe_n(oe1), .drv(drv1), .pin(in1));
    // Clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    // Bus write, each channel released at its own handshake
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) done = 1'b1;
        end
        `CHK("bresp", TCC_RESP_OKAY, bresp)
    endtask
    // Bus read with data and response check
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        bit done;
        done = 1'b0;
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) done = 1'b1;
        end
        `CHK("rdata", e, rdata)
        `CHK("rresp", er, rresp)
    endtask
    // Wait for pin A of channel 0 to reach a level
    task automatic wait_pin(input logic v);
        for (int i = 0; i < 200 && out0[0] !== v; i++) @(posedge clk);
        `CHK("pin_a0", v, out0[0])
    endtask
    task automatic t_regs;
        rd(12'h008, 32'h88, TCC_RESP_OKAY);
        rd(12'h00c, 32'h0, TCC_RESP_SLVERR);
        wr(12'h004, 32'hff);
        rd(12'h004, 32'h77, TCC_RESP_OKAY);
        $display("regs done");
    endtask
    task automatic t_compare;
        wr(TCC_ADR_GR, 32'h20);
        wr(12'h004, 32'h02);
        wr(12'h000, 32'h20);
        wr(12'h040, 32'h05);
        wr(12'h050, 32'h08);
        `CHK("oe_a0", 1'b0, oe0[0])
        wait_pin(1'b1);
        wr(12'h004, 32'h03);
        wait_pin(1'b0);
        wait_pin(1'b1);
        $display("compare done");
    endtask
    task automatic t_capture;
        wr(12'h044, 32'h04);
        // no buffering; C and D keep function select 1
        `CHK("oe_a1", 1'b1, oe1[0])
        drv1[0] <= 1'b1;
        ext <= 1'b1;
        repeat (6) @(posedge clk);
        ext <= 1'b0;
        rd(12'h070, 32'h0, TCC_RESP_OKAY);
        rd(TCC_ADR_CNT1, 32'h0, TCC_RESP_OKAY);
        $display("capture done");
    endtask
    task automatic t_ext;
        wr(12'h040, 32'h0d);
        wr(12'h050, 32'h09);
        repeat (3)
        begin
            ext <= 1'b1;
            repeat (4) @(posedge clk);
            ext <= 1'b0;
            repeat (4) @(posedge clk);
        end
        ext <= 1'b1;
        repeat (6) @(posedge clk);
        rd(TCC_ADR_CNT1, 32'h3, TCC_RESP_OKAY);
        $display("ext count done");
    endtask
    task automatic t_3ph;
        wr(12'h000, 32'h20);
        wr(12'h050, 32'h0d);
        ext <= 1'b0;
        repeat (6) @(posedge clk);
        ext <= 1'b1;
        repeat (6) @(posedge clk);
        rd(TCC_ADR_CNT1, 32'h3, TCC_RESP_OKAY);
        $display("three-phase done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        {arst_n, awv, wv, bready, arv, rready, ext, drv0, drv1} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_compare();
        t_capture();
        t_ext();
        t_3ph();
        end_of_test();
    end
endmodule
